// >>> hdl/gpm_cfg.svh
`ifndef GPM_CFG_SVH
`define GPM_CFG_SVH

// ==========================================================================
// Register placement
`define GPM_CTRL_ADDR          6'h0F
`define GPM_CTRL_RESET         24'h000001

// ==========================================================================
// Field positions of the control register
`define GPM_SEL_LSB            0
`define GPM_SEL_MSB            4
`define GPM_TEST_BIT           5
`define GPM_INHIBIT_BIT        6
`define GPM_ALWAYS_ON_BIT      7
`define GPM_HIGH_DRIVE_OFF_BIT 8

// ==========================================================================
// Source codes with special meaning
`define GPM_SRC_TEST           5'h00
`define GPM_SRC_PULL_UP        5'h05
`define GPM_SRC_PULL_DOWN      5'h06

// Codes that route a live internal signal
`define GPM_SRC_VALID_MASK     32'hC3FFFF1E

`endif

// >>> hdl/gpm_pkg.sv
package gpm_pkg;

  // ========================================================================
  // Types shared by the pin multiplexer
  typedef logic [4:0]  gpm_sel_t;
  typedef logic [23:0] gpm_word_t;

  // Weak termination applied to the pin
  typedef enum logic [2:0] {
    GPM_PULL_NONE = 3'b001,
    GPM_PULL_UP   = 3'b010,
    GPM_PULL_DOWN = 3'b100
  } gpm_pull_e;

endpackage : gpm_pkg

// >>> hdl/gpm_general_output_pin_mux.sv
`timescale 1ns/100ps
`include "gpm_cfg.svh"
module gpm_general_output_pin_mux #(
  parameter int ADDR_W = 6
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                nrst,
  // Register port from the serial interface core
  input  wire logic                reg_wr_en,
  input  wire logic                reg_rd_en,
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire gpm_pkg::gpm_word_t  reg_wdata,
  output gpm_pkg::gpm_word_t       reg_rdata,
  // Read cycle state and serial read data
  input  wire logic                read_cycle,
  input  wire logic                read_data_bit,
  // Settings held in other registers
  input  wire logic                pin_enable,
  input  wire logic                level_3v3_sel,
  // Internal sources, asynchronous to clk
  input  wire logic                lock_detect,
  input  wire logic                lock_trigger,
  input  wire logic                lock_window,
  input  wire logic                ring_osc_test,
  input  wire logic                ref_buffer_out,
  input  wire logic                ref_divider_out,
  input  wire logic                osc_divider_out,
  input  wire logic                modulator_div_clk,
  input  wire logic                aux_clock,
  input  wire logic                aux_serial_clk,
  input  wire logic                aux_serial_enable,
  input  wire logic                aux_serial_data,
  input  wire logic                phase_detector_down,
  input  wire logic                phase_detector_up,
  input  wire logic                modulator_clk_delay,
  input  wire logic                modulator_core_clk,
  input  wire logic                strobe_integer_wr,
  input  wire logic                strobe_fraction_wr,
  input  wire logic                strobe_aux_wr,
  input  wire logic                serial_latch_enable,
  input  wire logic                divider_sync_reset,
  input  wire logic                seed_load_strobe,
  input  wire logic                serial_out_buf_en,
  input  wire logic                soft_reset,
  // Lock/serial-out pin
  output logic                     pin_out,
  output logic                     pin_oe_n,
  output logic                     pin_pull_up_en,
  output logic                     pin_pull_down_en,
  output logic                     pin_high_drive_en,
  output logic                     pin_level_3v3
);
  import gpm_pkg::*;

  // ========================================================================
  // Reset release
  logic rst_meta_reg;
  logic rst_n;
  logic rst_meta_next;
  logic rst_n_next;

  // Release is synchronous so every flop reset by rst_n leaves reset on the same edge
  always_comb begin
    rst_meta_next = 1'b1;
    rst_n_next    = rst_meta_reg;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= rst_meta_next;
      rst_n        <= rst_n_next;
    end
  end

  // ========================================================================
  // Source vector, indexed by select code
  logic [31:0] src_async;

  always_comb begin
    src_async     = 32'h00000000;
    src_async[1]  = lock_detect;
    src_async[2]  = lock_trigger;
    src_async[3]  = lock_window;
    src_async[4]  = ring_osc_test;
    src_async[8]  = ref_buffer_out;
    src_async[9]  = ref_divider_out;
    src_async[10] = osc_divider_out;
    src_async[11] = modulator_div_clk;
    src_async[12] = aux_clock;
    src_async[13] = aux_serial_clk;
    src_async[14] = aux_serial_enable;
    src_async[15] = aux_serial_data;
    src_async[16] = phase_detector_down;
    src_async[17] = phase_detector_up;
    src_async[18] = modulator_clk_delay;
    src_async[19] = modulator_core_clk;
    src_async[20] = strobe_integer_wr;
    src_async[21] = strobe_fraction_wr;
    src_async[22] = strobe_aux_wr;
    src_async[23] = serial_latch_enable;
    src_async[24] = divider_sync_reset;
    src_async[25] = seed_load_strobe;
    src_async[30] = serial_out_buf_en;
    src_async[31] = soft_reset;
  end

  // ========================================================================
  // Two-stage synchronisers
  // Sources faster than half of clk are aliased; observe them as levels
  logic [31:0] src_meta_reg;
  logic [31:0] src_sync_reg;

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_sync
      logic meta_next;
      logic sync_next;

      always_comb begin
        meta_next = src_async[gi];
        sync_next = src_meta_reg[gi];
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          src_meta_reg[gi] <= 1'b0;
          src_sync_reg[gi] <= 1'b0;
        end else begin
          src_meta_reg[gi] <= meta_next;
          src_sync_reg[gi] <= sync_next;
        end
      end
    end
  endgenerate

  // ========================================================================
  // Control register
  gpm_word_t ctrl_reg;
  gpm_word_t ctrl_next;
  gpm_word_t rdata_next;
  logic      addr_hit;

  assign addr_hit = (reg_addr == `GPM_CTRL_ADDR);

  always_comb begin
    ctrl_next  = ctrl_reg;
    rdata_next = reg_rdata;
    if (reg_wr_en && addr_hit) begin
      ctrl_next = reg_wdata;
    end
    // Other registers live elsewhere; they read as zero here
    // A write and a read in one cycle return the old word
    if (reg_rd_en && addr_hit) begin
      rdata_next = ctrl_reg;
    end else if (reg_rd_en) begin
      rdata_next = 24'h000000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg  <= `GPM_CTRL_RESET;
      reg_rdata <= 24'h000000;
    end else begin
      ctrl_reg  <= ctrl_next;
      reg_rdata <= rdata_next;
    end
  end

  // ========================================================================
  // Field decode
  gpm_sel_t sel;
  logic     test_value;
  logic     inhibit;
  logic     always_on;
  logic     high_drive_off;

  assign sel            = ctrl_reg[`GPM_SEL_MSB:`GPM_SEL_LSB];
  assign test_value     = ctrl_reg[`GPM_TEST_BIT];
  assign inhibit        = ctrl_reg[`GPM_INHIBIT_BIT];
  assign always_on      = ctrl_reg[`GPM_ALWAYS_ON_BIT];
  assign high_drive_off = ctrl_reg[`GPM_HIGH_DRIVE_OFF_BIT];

  // ========================================================================
  // Source multiplexer
  logic      mux_out;
  gpm_pull_e pull;

  // Every code is listed so an unused one can never pick a stray bit
  always_comb begin
    mux_out = 1'b0;
    pull    = GPM_PULL_NONE;
    case (sel)
      `GPM_SRC_TEST: begin
        mux_out = test_value;
      end
      5'h01: mux_out = src_sync_reg[1];
      5'h02: mux_out = src_sync_reg[2];
      5'h03: mux_out = src_sync_reg[3];
      5'h04: mux_out = src_sync_reg[4];
      `GPM_SRC_PULL_UP: begin
        pull    = GPM_PULL_UP;
        mux_out = 1'b0;
      end
      `GPM_SRC_PULL_DOWN: begin
        pull    = GPM_PULL_DOWN;
        mux_out = 1'b0;
      end
      5'h07: mux_out = 1'b0;
      5'h08: mux_out = src_sync_reg[8];
      5'h09: mux_out = src_sync_reg[9];
      5'h0A: mux_out = src_sync_reg[10];
      5'h0B: mux_out = src_sync_reg[11];
      5'h0C: mux_out = src_sync_reg[12];
      5'h0D: mux_out = src_sync_reg[13];
      5'h0E: mux_out = src_sync_reg[14];
      5'h0F: mux_out = src_sync_reg[15];
      5'h10: mux_out = src_sync_reg[16];
      5'h11: mux_out = src_sync_reg[17];
      5'h12: mux_out = src_sync_reg[18];
      5'h13: mux_out = src_sync_reg[19];
      5'h14: mux_out = src_sync_reg[20];
      5'h15: mux_out = src_sync_reg[21];
      5'h16: mux_out = src_sync_reg[22];
      5'h17: mux_out = src_sync_reg[23];
      5'h18: mux_out = src_sync_reg[24];
      5'h19: mux_out = src_sync_reg[25];
      5'h1A: mux_out = 1'b0;
      5'h1B: mux_out = 1'b0;
      5'h1C: mux_out = 1'b0;
      5'h1D: mux_out = 1'b0;
      5'h1E: mux_out = src_sync_reg[30];
      5'h1F: mux_out = src_sync_reg[31];
      default: mux_out = 1'b0;
    endcase
  end

  // ========================================================================
  // Pin driver
  // A weak pull is only seen if the driver stays off outside reads
  // A disabled pin never shows the source, not even during a read
  logic drive_src;
  logic drive_en;
  logic out_next;
  logic oe_n_next;
  logic pu_next;
  logic pd_next;
  logic hd_next;
  logic lvl_next;
  logic use_read;

  always_comb begin
    use_read  = read_cycle && !inhibit;
    drive_src = pin_enable && (pull == GPM_PULL_NONE);
    drive_en  = use_read
                || (drive_src && (always_on || read_cycle));
    out_next  = use_read ? read_data_bit : mux_out;
    oe_n_next = !drive_en;
    pu_next   = (pull == GPM_PULL_UP) && !drive_en;
    pd_next   = (pull == GPM_PULL_DOWN) && !drive_en;
    hd_next   = !high_drive_off;
    lvl_next  = level_3v3_sel;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out           <= 1'b0;
      pin_oe_n          <= 1'b1;
      pin_pull_up_en    <= 1'b0;
      pin_pull_down_en  <= 1'b0;
      pin_high_drive_en <= 1'b1;
      pin_level_3v3     <= 1'b0;
    end else begin
      pin_out           <= out_next;
      pin_oe_n          <= oe_n_next;
      pin_pull_up_en    <= pu_next;
      pin_pull_down_en  <= pd_next;
      pin_high_drive_en <= hd_next;
      pin_level_3v3     <= lvl_next;
    end
  end

endmodule : gpm_general_output_pin_mux

// >>> sim/gpm_properties.sv
`timescale 1ns/100ps
// ==========================================================================
// Pin multiplexer checks
module gpm_properties (
  // Clock and reset
  input wire logic               clk,
  input wire logic               nrst,
  // Register port and pin controls
  input wire logic               reg_wr_en,
  input wire logic               reg_rd_en,
  input wire logic [5:0]         reg_addr,
  input wire gpm_pkg::gpm_word_t reg_wdata,
  input wire gpm_pkg::gpm_word_t reg_rdata,
  input wire logic               read_cycle,
  input wire logic               read_data_bit,
  input wire logic               pin_enable,
  input wire logic               level_3v3_sel,
  // Pin
  input wire logic               pin_out,
  input wire logic               pin_oe_n,
  input wire logic               pin_pull_up_en,
  input wire logic               pin_pull_down_en,
  input wire logic               pin_high_drive_en,
  input wire logic               pin_level_3v3
);
  import gpm_pkg::*;
  gpm_word_t sh_reg;
  gpm_word_t sh_next;
  logic [4:0] code;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Shadow of the control register, kept apart from the design's copy
  always_comb begin
    sh_next = sh_reg;
    if (reg_wr_en && reg_addr == 6'h0F) sh_next = reg_wdata;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) sh_reg <= 24'h000001;
    else sh_reg <= sh_next;
  end
  assign code = sh_reg[4:0];
  chk_read_back: assert property (
    reg_rd_en && reg_addr == 6'h0F |=> reg_rdata == $past(sh_reg))
    else $error("read back differs");
  chk_unmapped_zero: assert property (
    reg_rd_en && reg_addr != 6'h0F |=> reg_rdata == 24'h000000)
    else $error("unmapped read not zero");
  chk_read_drive: assert property (
    read_cycle && (!sh_reg[6] || pin_enable) |=> !pin_oe_n)
    else $error("pin idle in read");
  chk_source_gated: assert property (
    !pin_enable && !(read_cycle && !sh_reg[6]) |=> pin_oe_n)
    else $error("disabled pin driven");
  chk_driver_off: assert property (
    !read_cycle && !sh_reg[7] |=> pin_oe_n)
    else $error("pin driven outside read");
  chk_enable_drive: assert property (
    !read_cycle && sh_reg[7] && pin_enable && code != 5'h05
    && code != 5'h06 |=> !pin_oe_n)
    else $error("enabled pin idle");
  chk_read_data: assert property (
    read_cycle && !sh_reg[6] |=> pin_out == $past(read_data_bit))
    else $error("read bit not on pin");
  chk_test_value: assert property (
    !read_cycle && code == 5'h00 |=> pin_out == $past(sh_reg[5]))
    else $error("test value not on pin");
  chk_pull_up: assert property (
    !read_cycle && code == 5'h05 |=> pin_pull_up_en && !pin_out)
    else $error("pull up missing");
  chk_pull_down: assert property (
    !read_cycle && code == 5'h06 |=> pin_pull_down_en && !pin_out)
    else $error("pull down missing");
  chk_reserved_low: assert property (
    !read_cycle && (code == 5'h07 || code inside {[5'h1A:5'h1D]})
    |=> !pin_out)
    else $error("reserved code not low");
  chk_high_drive: assert property (
    ##1 pin_high_drive_en == !$past(sh_reg[8]))
    else $error("high drive wrong");
  chk_level_sel: assert property (
    ##1 pin_level_3v3 == $past(level_3v3_sel))
    else $error("drive level wrong");
  cover property (read_cycle && !sh_reg[6]);
  cover property (code == 5'h05);
  cover property (read_cycle && sh_reg[6] && pin_enable);
  cover property (reg_rd_en && reg_addr != 6'h0F);
endmodule : gpm_properties

// >>> sim/gpm_host_model.sv
`timescale 1ns/100ps
// ==========================================================================
// Host side: serial read cycles, eight bits MSB first
module gpm_host_model (
  // Clock and request
  input wire logic       clk,
  input wire logic       start,
  input wire logic [7:0] pattern,
  // Read cycle outputs
  output logic           read_cycle,
  output logic           read_data_bit
);
  int left;
  logic [7:0] sh;
  initial begin
    read_cycle = 1'b0;
    read_data_bit = 1'b0;
    left = 0;
  end
  always @(negedge clk) begin
    if (start && left == 0) begin
      left = 8;
      sh = pattern;
    end
    if (left > 0) begin
      read_cycle <= 1'b1;
      read_data_bit <= sh[7];
      sh = sh << 1;
      left--;
    end else begin
      read_cycle <= 1'b0;
      // Released line toggles so a stale bit is never mistaken for data
      read_data_bit <= ~read_data_bit;
    end
  end
endmodule : gpm_host_model

// >>> sim/test_general_output_pin_mux.sv
`timescale 1ns/100ps
module test_general_output_pin_mux;
  import gpm_pkg::*;
  logic clk, nrst, wr, rd, rcyc, rbit, pen, lvl, start;
  logic pout, oe_n, pu, pd, hd, l33;
  logic [5:0] addr;
  logic [7:0] pat;
  logic [31:0] src;
  gpm_word_t wdata, rdata, c, got;
  int bad_count, comparisons;
  gpm_general_output_pin_mux DUT (
    .clk(clk), .nrst(nrst), .reg_wr_en(wr), .reg_rd_en(rd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .read_cycle(rcyc), .read_data_bit(rbit), .pin_enable(pen),
    .level_3v3_sel(lvl), .lock_detect(src[1]), .lock_trigger(src[2]),
    .lock_window(src[3]), .ring_osc_test(src[4]),
    .ref_buffer_out(src[8]), .ref_divider_out(src[9]),
    .osc_divider_out(src[10]), .modulator_div_clk(src[11]),
    .aux_clock(src[12]), .aux_serial_clk(src[13]),
    .aux_serial_enable(src[14]), .aux_serial_data(src[15]),
    .phase_detector_down(src[16]), .phase_detector_up(src[17]),
    .modulator_clk_delay(src[18]), .modulator_core_clk(src[19]),
    .strobe_integer_wr(src[20]), .strobe_fraction_wr(src[21]),
    .strobe_aux_wr(src[22]), .serial_latch_enable(src[23]),
    .divider_sync_reset(src[24]), .seed_load_strobe(src[25]),
    .serial_out_buf_en(src[30]), .soft_reset(src[31]),
    .pin_out(pout), .pin_oe_n(oe_n), .pin_pull_up_en(pu),
    .pin_pull_down_en(pd), .pin_high_drive_en(hd), .pin_level_3v3(l33));
  gpm_host_model u_host (.clk(clk), .start(start), .pattern(pat),
    .read_cycle(rcyc), .read_data_bit(rbit));
  task automatic check(string n, logic [23:0] e, logic [23:0] s);
    comparisons++;
    if (e !== s) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask : check
  task automatic wr_reg(logic [5:0] a, gpm_word_t d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_reg
  task automatic rd_reg(logic [5:0] a, output gpm_word_t d);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask : rd_reg
  // Expected pin level from the source code table
  function automatic logic model_pin(gpm_word_t w, logic [31:0] s);
    logic [31:0] live;
    live = 32'hC3FFFF1E;
    if (w[4:0] == 5'h00) return w[5];
    return live[w[4:0]] & s[w[4:0]];
  endfunction : model_pin
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #400000;
    bad_count++;
    close_out;
  end
  initial begin
    {nrst, wr, rd, pen, lvl, start, addr, pat, src, wdata} = '0;
    bad_count = 0;
    comparisons = 0;
    void'($urandom(7));
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    rd_reg(6'h0F, got);
    check("reset value", 24'h000001, got);
    check("reset oe_n", 1'b1, oe_n);
    wr_reg(6'h10, 24'hFFFFFF);
    rd_reg(6'h10, got);
    check("unmapped", 24'h000000, got);
    rd_reg(6'h0F, got);
    check("after stray write", 24'h000001, got);
    for (int k = 0; k < 32; k++) begin
      c = ($urandom & 24'hFFFF20) | 24'h0000C0 | k;
      pen = $urandom;
      lvl = $urandom;
      src = $urandom;
      wr_reg(6'h0F, c);
      repeat (4) @(negedge clk);
      check("pin_out", model_pin(c, src), pout);
      check("oe_n", !(pen && k != 5 && k != 6), oe_n);
      check("pull up", k == 5, pu);
      check("pull down", k == 6, pd);
      check("high drive", !c[8], hd);
      check("level", lvl, l33);
      rd_reg(6'h0F, got);
      check("read back", c, got);
    end
    for (int i = 0; i < 3; i++) begin
      pen = (i == 2);
      wr_reg(6'h0F, (i == 0) ? 24'h000001 : 24'h000041);
      pat = $urandom;
      start <= 1'b1;
      @(negedge clk);
      start <= 1'b0;
      repeat (12) begin
        @(negedge clk);
        check("read oe_n", !(rcyc && (i != 1)), oe_n);
        if (rcyc)
          check("read pin", (i != 0) ? src[1] : rbit, pout);
      end
    end
    close_out;
  end
endmodule : test_general_output_pin_mux
bind gpm_general_output_pin_mux gpm_properties u_chk (
  .clk(clk), .nrst(nrst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .read_cycle(read_cycle), .read_data_bit(read_data_bit),
  .pin_enable(pin_enable), .level_3v3_sel(level_3v3_sel),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n),
  .pin_pull_up_en(pin_pull_up_en), .pin_pull_down_en(pin_pull_down_en),
  .pin_high_drive_en(pin_high_drive_en), .pin_level_3v3(pin_level_3v3));
